// ### igc_consts.svh
// Register offsets, field ranges, reset values and fs-based timing counts.
// Assumes a single 200 MHz clock and a half-sample-period tick from the datapath.
`ifndef IGC_CONSTS_SVH
`define IGC_CONSTS_SVH

`define IGC_A_TIMER     8'h08
`define IGC_A_MODE      8'h09
`define IGC_A_CEIL      8'h0a
`define IGC_A_GAIN_L    8'h0b
`define IGC_A_ATT_L     8'h0c
`define IGC_A_ATT_R     8'h0d
`define IGC_A_MIX       8'h0e
`define IGC_A_GAIN_R    8'h0f
`define IGC_A_PWR3      8'h10
`define IGC_A_PWR_AUX   8'h11
`define IGC_A_STATUS    8'h12

`define IGC_R_TIMER     8'h00
`define IGC_R_MODE      7'h40
`define IGC_R_CEIL      7'h36
`define IGC_R_GAIN      7'h10
`define IGC_R_ATT       8'h00
`define IGC_R_MIX       4'h0
`define IGC_R_PWR3      5'h00
`define IGC_R_PWR_AUX   4'h0
`define IGC_GAIN_MIN    7'h00

`define IGC_F_GAIN      6:0
`define IGC_F_ZTM       5:4
`define IGC_F_WTM       3:2
`define IGC_F_LTM       1:0
`define IGC_F_MODE      6:0
`define IGC_F_MIX       7:4
`define IGC_F_PWR3      4:0
`define IGC_F_AUX       3:0
`define IGC_F_STAT      2:0

`define IGC_HALF_PER_FS 2
`define IGC_ZTO_BASE_FS 128
`define IGC_WAIT_BASE_FS 128
`define IGC_SPK_INIT_FS 2048
`define IGC_ADC_INIT_FS 2081

`endif

// ### igc_pkg.sv
// Types shared by the input gain and level-control block.
// Constants live in igc_consts.svh; this package holds types only.
package igc_pkg;

    typedef enum logic [1:0] {
        IGC_INIT_IDLE  = 2'b00,
        IGC_INIT_COUNT = 2'b01,
        IGC_INIT_DONE  = 2'b11
    } igc_init_t;

    typedef struct packed {
        logic speaker_power;
        logic left_gain_stage_power;
        logic left_mic_power;
        logic left_adc_power;
    } igc_aux_t;

    typedef struct packed {
        logic right_source_sel;
        logic left_source_sel;
        logic right_gain_stage_power;
        logic right_mic_power;
        logic right_adc_power;
    } igc_pwr3_t;

    typedef struct packed {
        logic speaker_limiter_en;
        logic input_level_ctrl_en;
        logic limiter_zero_cross_disable;
        logic [1:0] limiter_step_sel;
        logic recovery_step_sel;
        logic limiter_threshold_sel;
    } igc_mode_t;

    typedef struct packed {
        logic adc_left;
        logic adc_right;
        logic adc_digital;
        logic mic_left;
        logic mic_right;
        logic gain_stage_left;
        logic gain_stage_right;
    } igc_pwr_t;

endpackage

// ### igc_input_gain_alc_control.sv
// Recording-path gain control: host registers, automatic level control,
// power decode and initialisation timers for the ADC and speaker limiter.
// Assumes level, zero-cross and half-fs tick inputs come from same-clock logic.
//
// Functional notes
// RULE1 - Limiter event lowers gain code by 1 to 4 per step setting.
// RULE2 - Limiter attenuation below code zero clips at zero.
// RULE3 - Zero-cross enabled: each channel applies change at crossing or timeout.
// RULE4 - Limiter zero-cross timeout equals recovery timeout.
// RULE5 - Zero-cross disabled: limiter changes apply immediately.
// RULE6 - Level control runs only when enable is one; resets disabled.
// RULE7 - Speaker limiter enable resets one; active 2048/fs after power rise.
// RULE8 - Recovery never raises gain above ceiling; ceiling resets 36H.
// RULE9 - Seven-bit gain code, 0.5dB steps, 00 to 47, reset 10H; host writes above 47 are taken unclamped.
// RULE10 - Host writes gain only with stage powered and control disabled.
// RULE11 - All mic/gain power off resets gain; restart from 10H.
// RULE12 - Disabling level control holds last automatic gain.
// RULE13 - Gain register reads return last host write.
// RULE14 - Eight-bit output attenuation per channel, reset 00H.
// RULE15 - Three-bit stereo mixer attenuation field, 3dB steps.
// RULE16 - One bit mono mixer attenuation, 0dB or -4dB.
// RULE17 - ADC power rise starts 2081/fs init; data valid afterward.
// RULE18 - ADC analog per channel; digital when either bit set.
// RULE19 - Right gain stage on with mic or stage bit; mic own bit.
// RULE20 - Source select: zero mic input, one line input.
// RULE21 - Recovery raises gain by 1 or 2 codes.
// RULE22 - Zero-cross timeout 128/fs to 1024/fs, reset 00.
// RULE23 - Immediate limiter repeat period 0.5/fs to 4/fs.
// RULE24 - Recovery steps only after quiet wait 128/fs to 1024/fs.
// RULE25 - Applied gain kept apart from host-written register.
// RULE26 - Zero bits read zero; writes to them ignored.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "igc_consts.svh"

module igc_input_gain_alc_control (
    // Clock and reset
    input  wire logic              CLOCK_IN,
    input  wire logic              SYS_RST_IN,
    // Register port
    input  wire logic [7:0]        ADDR_IN,
    input  wire logic [7:0]        WDATA_IN,
    input  wire logic              WR_IN,
    input  wire logic              RD_IN,
    output logic      [7:0]        RDATA_OUT,
    // Datapath timing and level detect
    input  wire logic              FS_HALF_TICK_IN,
    input  wire logic [1:0]        LEVEL_OVER_IN,
    input  wire logic [1:0]        ZERO_CROSS_IN,
    // Applied gain and analog controls
    output logic      [6:0]        GAIN_L_OUT,
    output logic      [6:0]        GAIN_R_OUT,
    output logic                   LIMIT_THRESH_OUT,
    output logic      [1:0]        SRC_SEL_OUT,
    output logic      [7:0]        ATTEN_L_OUT,
    output logic      [7:0]        ATTEN_R_OUT,
    output logic      [2:0]        STEREO_MIX_ATTEN_OUT,
    output logic                   MONO_MIX_ATTEN_OUT,
    // Power and status
    output igc_pkg::igc_pwr_t      PWR_OUT,
    output logic                   ADC_DATA_VALID_OUT,
    output logic                   SPK_LIMITER_ACTIVE_OUT
);

    localparam logic [11:0] ZTO_BASE =
        12'(`IGC_ZTO_BASE_FS * `IGC_HALF_PER_FS);
    localparam logic [11:0] WAIT_BASE =
        12'(`IGC_WAIT_BASE_FS * `IGC_HALF_PER_FS);
    localparam logic [12:0] SPK_INIT =
        13'(`IGC_SPK_INIT_FS * `IGC_HALF_PER_FS);
    localparam logic [12:0] ADC_INIT =
        13'(`IGC_ADC_INIT_FS * `IGC_HALF_PER_FS);

    // Host registers
    logic [7:0]           timer_sel;
    igc_pkg::igc_mode_t   mode;
    logic [6:0]           ceiling;
    logic [6:0]           host_gain [2];
    logic [7:0]           atten_l;
    logic [7:0]           atten_r;
    logic [3:0]           mix_att;
    igc_pkg::igc_pwr3_t   pwr3;
    igc_pkg::igc_aux_t    aux;

    // Level-control state
    logic [6:0]           gain [2];
    logic [6:0]           target [2];
    logic                 pend [2];
    logic [1:0]           host_wr;
    logic [3:0]           lim_cnt;
    logic [11:0]          wait_cnt;
    logic [7:0]           rd_mux;

    logic                 pwr_any;
    logic                 alc_on;
    logic                 over_any;
    logic [3:0]           lim_per;
    logic [11:0]          zto;
    logic [11:0]          wper;
    logic                 lim_tick;
    logic                 limit_ev;
    logic                 rec_ev;
    logic [2:0]           lim_step;
    logic [1:0]           rec_step;

    igc_pkg::igc_init_t   adc_st;
    igc_pkg::igc_init_t   spk_st;
    logic [12:0]          adc_cnt;
    logic [12:0]          spk_cnt;
    logic                 adc_l_q;
    logic                 adc_r_q;
    logic                 spk_q;
    logic                 adc_rise;
    logic                 spk_rise;

    // RULE26 zero bits masked
    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            timer_sel <= `IGC_R_TIMER;
            mode      <= igc_pkg::igc_mode_t'(`IGC_R_MODE);
            ceiling   <= `IGC_R_CEIL;
            atten_l   <= `IGC_R_ATT;
            atten_r   <= `IGC_R_ATT;
            mix_att   <= `IGC_R_MIX;
            pwr3      <= igc_pkg::igc_pwr3_t'(`IGC_R_PWR3);
            aux       <= igc_pkg::igc_aux_t'(`IGC_R_PWR_AUX);
        end else if (WR_IN) begin
            unique case (ADDR_IN)
                `IGC_A_TIMER: begin
                    timer_sel <= {2'h0, WDATA_IN[5:0]};
                end
                `IGC_A_MODE: begin
                    mode <= igc_pkg::igc_mode_t'(WDATA_IN[`IGC_F_MODE]);
                end
                // RULE8 ceiling register
                `IGC_A_CEIL: begin
                    ceiling <= WDATA_IN[`IGC_F_GAIN];
                end
                // RULE14 output attenuation
                `IGC_A_ATT_L: begin
                    atten_l <= WDATA_IN;
                end
                `IGC_A_ATT_R: begin
                    atten_r <= WDATA_IN;
                end
                // RULE15 RULE16 mixer fields
                `IGC_A_MIX: begin
                    mix_att <= WDATA_IN[`IGC_F_MIX];
                end
                `IGC_A_PWR3: begin
                    pwr3 <= igc_pkg::igc_pwr3_t'(WDATA_IN[`IGC_F_PWR3]);
                end
                `IGC_A_PWR_AUX: begin
                    aux <= igc_pkg::igc_aux_t'(WDATA_IN[`IGC_F_AUX]);
                end
                default: begin
                end
            endcase
        end
    end

    // RULE13 host copy kept for readback
    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            host_gain[0] <= `IGC_R_GAIN;
            host_gain[1] <= `IGC_R_GAIN;
        end else if (WR_IN) begin
            if (ADDR_IN == `IGC_A_GAIN_L) begin
                host_gain[0] <= WDATA_IN[`IGC_F_GAIN];
            end
            if (ADDR_IN == `IGC_A_GAIN_R) begin
                host_gain[1] <= WDATA_IN[`IGC_F_GAIN];
            end
        end
    end

    assign host_wr[0] = WR_IN && (ADDR_IN == `IGC_A_GAIN_L);
    assign host_wr[1] = WR_IN && (ADDR_IN == `IGC_A_GAIN_R);

    always_comb begin
        unique case (ADDR_IN)
            `IGC_A_TIMER:   rd_mux = timer_sel;
            `IGC_A_MODE:    rd_mux = {1'b0, mode};
            `IGC_A_CEIL:    rd_mux = {1'b0, ceiling};
            `IGC_A_GAIN_L:  rd_mux = {1'b0, host_gain[0]};
            `IGC_A_ATT_L:   rd_mux = atten_l;
            `IGC_A_ATT_R:   rd_mux = atten_r;
            `IGC_A_MIX:     rd_mux = {mix_att, 4'h0};
            `IGC_A_GAIN_R:  rd_mux = {1'b0, host_gain[1]};
            `IGC_A_PWR3:    rd_mux = {3'h0, pwr3};
            `IGC_A_PWR_AUX: rd_mux = {4'h0, aux};
            `IGC_A_STATUS:  rd_mux = {5'h0, ADC_DATA_VALID_OUT,
                                      SPK_LIMITER_ACTIVE_OUT, alc_on};
            default:        rd_mux = 8'h00;
        endcase
    end

    // Data only in the cycle after the strobe
    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            RDATA_OUT <= 8'h00;
        end else begin
            RDATA_OUT <= RD_IN ? rd_mux : 8'h00;
        end
    end

    // RULE11 any mic or gain stage powered
    assign pwr_any  = aux.left_mic_power | aux.left_gain_stage_power |
                      pwr3.right_mic_power | pwr3.right_gain_stage_power;
    // RULE6 runs only when enabled
    assign alc_on   = mode.input_level_ctrl_en & pwr_any;
    assign over_any = |LEVEL_OVER_IN;
    // RULE23 immediate repeat period in half ticks
    assign lim_per  = 4'h1 << timer_sel[`IGC_F_LTM];
    // RULE22 RULE4 one timeout for all changes
    assign zto      = ZTO_BASE << timer_sel[`IGC_F_ZTM];
    // RULE24 quiet wait before recovery
    assign wper     = WAIT_BASE << timer_sel[`IGC_F_WTM];
    assign lim_step = {1'b0, mode.limiter_step_sel} + 3'h1;
    assign rec_step = {1'b0, mode.recovery_step_sel} + 2'h1;
    assign lim_tick = FS_HALF_TICK_IN && (lim_cnt == lim_per - 4'h1);

    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            lim_cnt <= 4'h0;
        end else if (!alc_on || lim_tick) begin
            lim_cnt <= 4'h0;
        end else if (FS_HALF_TICK_IN) begin
            lim_cnt <= lim_cnt + 4'h1;
        end
    end

    // RULE1 either channel over threshold
    // RULE5 immediate mode paced by period
    assign limit_ev = alc_on && over_any &&
                      (mode.limiter_zero_cross_disable ? lim_tick : (!pend[0] && !pend[1]));

    // RULE24 limiter activity restarts the wait
    assign rec_ev = alc_on && !over_any && !pend[0] && !pend[1] &&
                    FS_HALF_TICK_IN && (wait_cnt == wper - 12'h1);

    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            wait_cnt <= 12'h000;
        end else if (!alc_on || over_any || rec_ev) begin
            wait_cnt <= 12'h000;
        end else if (FS_HALF_TICK_IN && wait_cnt != wper - 12'h1) begin
            wait_cnt <= wait_cnt + 12'h001;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic [11:0] to_cnt;
            logic [6:0]  lim_val;
            logic [7:0]  rec_sum;
            logic [6:0]  rec_val;
            logic        apply;

            // RULE2 clip at lowest code
            assign lim_val = (gain[ch] > 7'(lim_step)) ?
                             gain[ch] - 7'(lim_step) : `IGC_GAIN_MIN;
            // RULE21 step of one or two codes
            assign rec_sum = {1'b0, gain[ch]} + {6'h00, rec_step};
            // RULE8 hold at ceiling
            assign rec_val = (gain[ch] >= ceiling) ? gain[ch] :
                             (rec_sum > {1'b0, ceiling}) ? ceiling : rec_sum[6:0];
            // RULE3 crossing or timeout per channel
            assign apply = pend[ch] && (ZERO_CROSS_IN[ch] ||
                           (FS_HALF_TICK_IN && to_cnt == zto - 12'h1));

            // RULE25 applied gain separate from host copy
            always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
                if (SYS_RST_IN) begin
                    gain[ch]   <= `IGC_R_GAIN;
                    target[ch] <= `IGC_R_GAIN;
                    pend[ch]   <= 1'b0;
                    to_cnt     <= 12'h000;
                // RULE11 reset while unpowered
                end else if (!pwr_any) begin
                    gain[ch]   <= `IGC_R_GAIN;
                    target[ch] <= `IGC_R_GAIN;
                    pend[ch]   <= 1'b0;
                    to_cnt     <= 12'h000;
                // RULE5 immediate limiter change
                end else if (limit_ev && mode.limiter_zero_cross_disable) begin
                    gain[ch] <= lim_val;
                    pend[ch] <= 1'b0;
                // RULE1 attenuate at next crossing
                end else if (limit_ev) begin
                    target[ch] <= lim_val;
                    pend[ch]   <= 1'b1;
                    to_cnt     <= 12'h000;
                end else if (rec_ev) begin
                    target[ch] <= rec_val;
                    pend[ch]   <= 1'b1;
                    to_cnt     <= 12'h000;
                // RULE12 disabled control leaves gain held
                // RULE10 host write taken only when control off
                end else if (host_wr[ch] && !mode.input_level_ctrl_en) begin
                    target[ch] <= WDATA_IN[`IGC_F_GAIN];
                    pend[ch]   <= 1'b1;
                    to_cnt     <= 12'h000;
                end else if (apply) begin
                    // RULE9 code range kept by host
                    gain[ch] <= target[ch];
                    pend[ch] <= 1'b0;
                    to_cnt   <= 12'h000;
                end else if (pend[ch] && FS_HALF_TICK_IN) begin
                    to_cnt <= to_cnt + 12'h001;
                end
            end
        end
    endgenerate

    assign adc_rise = (pwr3.right_adc_power & ~adc_r_q) |
                      (aux.left_adc_power & ~adc_l_q);
    assign spk_rise = aux.speaker_power & ~spk_q;

    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            adc_l_q <= 1'b0;
            adc_r_q <= 1'b0;
            spk_q   <= 1'b0;
        end else begin
            adc_l_q <= aux.left_adc_power;
            adc_r_q <= pwr3.right_adc_power;
            spk_q   <= aux.speaker_power;
        end
    end

    // RULE17 ADC initialisation cycle
    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            adc_st  <= igc_pkg::IGC_INIT_IDLE;
            adc_cnt <= 13'h0000;
        end else if (!(aux.left_adc_power | pwr3.right_adc_power)) begin
            adc_st <= igc_pkg::IGC_INIT_IDLE;
        end else if (adc_rise) begin
            adc_st  <= igc_pkg::IGC_INIT_COUNT;
            adc_cnt <= 13'h0000;
        end else if (adc_st == igc_pkg::IGC_INIT_COUNT && FS_HALF_TICK_IN) begin
            if (adc_cnt == ADC_INIT - 13'h1) begin
                adc_st <= igc_pkg::IGC_INIT_DONE;
            end
            adc_cnt <= adc_cnt + 13'h0001;
        end
    end

    // RULE7 speaker limiter initialisation
    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            spk_st  <= igc_pkg::IGC_INIT_IDLE;
            spk_cnt <= 13'h0000;
        end else if (!aux.speaker_power) begin
            spk_st <= igc_pkg::IGC_INIT_IDLE;
        end else if (spk_rise) begin
            spk_st  <= igc_pkg::IGC_INIT_COUNT;
            spk_cnt <= 13'h0000;
        end else if (spk_st == igc_pkg::IGC_INIT_COUNT && FS_HALF_TICK_IN) begin
            if (spk_cnt == SPK_INIT - 13'h1) begin
                spk_st <= igc_pkg::IGC_INIT_DONE;
            end
            spk_cnt <= spk_cnt + 13'h0001;
        end
    end

    // Outputs registered; one cycle behind their source state
    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            GAIN_L_OUT             <= `IGC_R_GAIN;
            GAIN_R_OUT             <= `IGC_R_GAIN;
            ADC_DATA_VALID_OUT     <= 1'b0;
            SPK_LIMITER_ACTIVE_OUT <= 1'b0;
            PWR_OUT                <= '0;
        end else begin
            GAIN_L_OUT             <= gain[0];
            GAIN_R_OUT             <= gain[1];
            ADC_DATA_VALID_OUT     <= adc_st == igc_pkg::IGC_INIT_DONE;
            SPK_LIMITER_ACTIVE_OUT <= mode.speaker_limiter_en &&
                                      spk_st == igc_pkg::IGC_INIT_DONE;
            // RULE18 ADC analog and digital power
            PWR_OUT.adc_left         <= aux.left_adc_power;
            PWR_OUT.adc_right        <= pwr3.right_adc_power;
            PWR_OUT.adc_digital      <= aux.left_adc_power | pwr3.right_adc_power;
            // RULE19 mic amp own bit, stage either
            PWR_OUT.mic_left         <= aux.left_mic_power;
            PWR_OUT.mic_right        <= pwr3.right_mic_power;
            PWR_OUT.gain_stage_left  <= aux.left_mic_power |
                                        aux.left_gain_stage_power;
            PWR_OUT.gain_stage_right <= pwr3.right_mic_power |
                                        pwr3.right_gain_stage_power;
        end
    end

    assign LIMIT_THRESH_OUT     = mode.limiter_threshold_sel;
    // RULE20 source select per channel
    assign SRC_SEL_OUT          = {pwr3.right_source_sel, pwr3.left_source_sel};
    assign ATTEN_L_OUT          = atten_l;
    assign ATTEN_R_OUT          = atten_r;
    assign STEREO_MIX_ATTEN_OUT = mix_att[2:0];
    assign MONO_MIX_ATTEN_OUT   = mix_att[3];

endmodule

// ### igc_chk.sv
// Port checker for the recording gain control block.
// Assumes one clock, active-high async reset, bound onto the top module.
`timescale 1ns/1ps
`include "igc_consts.svh"
module igc_chk (
    // Clock and reset
    input  wire logic              CLOCK_IN,
    input  wire logic              SYS_RST_IN,
    // Register port
    input  wire logic [7:0]        ADDR_IN,
    input  wire logic [7:0]        WDATA_IN,
    input  wire logic              WR_IN,
    // Controls and status
    input  wire logic [6:0]        GAIN_L_OUT,
    input  wire logic [6:0]        GAIN_R_OUT,
    input  wire logic [1:0]        SRC_SEL_OUT,
    input  wire logic [7:0]        ATTEN_L_OUT,
    input  wire logic [7:0]        ATTEN_R_OUT,
    input  wire logic [2:0]        STEREO_MIX_ATTEN_OUT,
    input  wire logic              MONO_MIX_ATTEN_OUT,
    input  wire igc_pkg::igc_pwr_t PWR_OUT,
    input  wire logic              ADC_DATA_VALID_OUT
);
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (SYS_RST_IN);
    logic gain_off;
    assign gain_off = !(PWR_OUT.mic_left | PWR_OUT.mic_right | PWR_OUT.gain_stage_left
                        | PWR_OUT.gain_stage_right);
    sequence wr_to(logic [7:0] a);
        WR_IN && ADDR_IN == a;
    endsequence
    sequence adc_start;
        $rose(PWR_OUT.adc_digital);
    endsequence
    chk_att_left: assert property (wr_to(`IGC_A_ATT_L) |=> ATTEN_L_OUT == $past(WDATA_IN))
        else $error("left attenuation not taken");
    chk_att_right: assert property (wr_to(`IGC_A_ATT_R) |=> ATTEN_R_OUT == $past(WDATA_IN))
        else $error("right attenuation not taken");
    chk_mix_write: assert property (wr_to(`IGC_A_MIX) |=>
        {MONO_MIX_ATTEN_OUT, STEREO_MIX_ATTEN_OUT} == $past(WDATA_IN[7:4]))
        else $error("mixer attenuation not taken");
    chk_src_write: assert property (wr_to(`IGC_A_PWR3) |=> SRC_SEL_OUT == $past(WDATA_IN[4:3]))
        else $error("source select not taken");
    chk_adc_digital: assert property (PWR_OUT.adc_digital == (PWR_OUT.adc_left | PWR_OUT.adc_right))
        else $error("adc digital power decode wrong");
    chk_right_stage: assert property (PWR_OUT.mic_right |-> PWR_OUT.gain_stage_right)
        else $error("right gain stage off with mic on");
    chk_adc_init: assert property (adc_start |-> !ADC_DATA_VALID_OUT [*8])
        else $error("adc valid during init");
    chk_valid_cause: assert property ($rose(ADC_DATA_VALID_OUT) |->
        $past(PWR_OUT.adc_digital, 8) && PWR_OUT.adc_digital)
        else $error("adc valid without powered adc");
    chk_gain_off: assert property (gain_off [*3] |->
        GAIN_L_OUT == `IGC_R_GAIN && GAIN_R_OUT == `IGC_R_GAIN)
        else $error("gain not reset while unpowered");
endmodule

bind igc_input_gain_alc_control igc_chk u_igc_chk (
    .CLOCK_IN(CLOCK_IN), .SYS_RST_IN(SYS_RST_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
    .WR_IN(WR_IN), .GAIN_L_OUT(GAIN_L_OUT), .GAIN_R_OUT(GAIN_R_OUT), .SRC_SEL_OUT(SRC_SEL_OUT),
    .ATTEN_L_OUT(ATTEN_L_OUT), .ATTEN_R_OUT(ATTEN_R_OUT), .PWR_OUT(PWR_OUT),
    .STEREO_MIX_ATTEN_OUT(STEREO_MIX_ATTEN_OUT), .MONO_MIX_ATTEN_OUT(MONO_MIX_ATTEN_OUT),
    .ADC_DATA_VALID_OUT(ADC_DATA_VALID_OUT));

// ### igc_host_model.sv
// Host model: drives the register port and notes expected read data.
// Assumes one clock; every signal changes just after a rising edge.
`timescale 1ns/1ps
module igc_host_model (
    // Clock
    input  wire logic       clk_in,
    // Register port
    output logic [7:0]      addr_out = 8'h00,
    output logic [7:0]      wdata_out = 8'h00,
    output logic            wr_out = 1'b0,
    output logic            rd_out = 1'b0
);
    logic [7:0] exp_q [$];
    // caller orders gain writes
    // Idle edge after each strobe so no signal is set twice per step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr_out <= a;
        rd_out <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_in);
        rd_out <= 1'b0;
        @(posedge clk_in);
    endtask
endmodule

// ### tb_input_gain_alc_control.sv
// Self-checking bench for the recording gain control block.
// Assumes the host model owns the register port; level inputs come from here.
`timescale 1ns/1ps
`include "igc_consts.svh"
module tb_input_gain_alc_control;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [7:0]        addr, wdata, rdata, att_l, att_r, rnd, g;
    logic              wr, rd, rd_d = 1'b0, thr, mmix, valid, spk;
    logic [1:0]        over, zc, src;
    logic [6:0]        gain_l, gain_r;
    logic [2:0]        smix;
    igc_pkg::igc_pwr_t pwr;
    int                err_total = 0;
    int                compares = 0;
    integer            seed = 32'h9029;
    localparam logic [7:0] RST_V [12] = '{8'h00, 8'h40, 8'h36, 8'h10, 8'h00, 8'h00,
                                          8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] RW_A [8] = '{8'h08, 8'h09, 8'h0a, 8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h11};
    localparam logic [7:0] MASK [8] = '{8'h3f, 8'h7f, 8'h7f, 8'hff, 8'hff, 8'hf0, 8'h1f, 8'h0f};

    always #2.5 clk = ~clk;

    igc_host_model u_igc_host_model (.clk_in(clk), .addr_out(addr), .wdata_out(wdata),
        .wr_out(wr), .rd_out(rd));
    // Half tick every cycle keeps the fs counts short
    igc_input_gain_alc_control u_igc_input_gain_alc_control (
        .CLOCK_IN(clk), .SYS_RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .FS_HALF_TICK_IN(1'b1), .LEVEL_OVER_IN(over),
        .ZERO_CROSS_IN(zc), .GAIN_L_OUT(gain_l), .GAIN_R_OUT(gain_r), .LIMIT_THRESH_OUT(thr),
        .SRC_SEL_OUT(src), .ATTEN_L_OUT(att_l), .ATTEN_R_OUT(att_r),
        .STEREO_MIX_ATTEN_OUT(smix), .MONO_MIX_ATTEN_OUT(mmix), .PWR_OUT(pwr),
        .ADC_DATA_VALID_OUT(valid), .SPK_LIMITER_ACTIVE_OUT(spk));

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic give_verdict;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        cyc(8);
        rst <= 1'b0;
        cyc(1);
    endtask
    task automatic gains(input logic [7:0] want);
        check({1'b0, gain_l}, want);
        check({1'b0, gain_r}, want);
    endtask

    // Read answer stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_d) check(rdata, u_igc_host_model.exp_q.pop_front());
        rd_d <= rd;
    end

    initial begin
        #100us;
        err_total++;
        give_verdict;
    end

    initial begin
        over = 2'b00;
        zc = 2'b00;
        do_reset;
        for (int a = 0; a < 12; a++) u_igc_host_model.rd(8'h08 + a[7:0], RST_V[a]);
        for (int a = 0; a < 8; a++) begin
            rnd = $random(seed);
            if (a == 1) rnd[5] = 1'b0;
            u_igc_host_model.wr(RW_A[a], rnd);
            u_igc_host_model.rd(RW_A[a], rnd & MASK[a]);
            if (a == 1) check({7'h00, thr}, {7'h00, rnd[0]});
        end
        u_igc_host_model.wr(8'h13, 8'hff);
        u_igc_host_model.rd(8'h13, 8'h00);
        $display("test registers done");
        do_reset;
        u_igc_host_model.wr(`IGC_A_PWR_AUX, 8'h02);
        u_igc_host_model.wr(`IGC_A_GAIN_L, 8'h47);
        u_igc_host_model.wr(`IGC_A_GAIN_R, 8'h47);
        zc <= 2'b11;
        cyc(1);
        zc <= 2'b00;
        cyc(3);
        gains(8'h47);
        g = 8'h47;
        for (int s = 3; s >= 0; s--) begin
            u_igc_host_model.wr(`IGC_A_MODE, 8'h70 | (s[7:0] << 2));
            over <= 2'b01;
            cyc(1);
            over <= 2'b00;
            cyc(3);
            g = g - 8'(s + 1);
            gains(g);
        end
        over <= 2'b10;
        cyc(70);
        over <= 2'b00;
        cyc(3);
        gains(8'h00);
        u_igc_host_model.rd(`IGC_A_GAIN_L, 8'h47);
        u_igc_host_model.wr(`IGC_A_MODE, 8'h5c);
        cyc(300);
        gains(8'h00);
        $display("test limiter done");
        u_igc_host_model.wr(`IGC_A_CEIL, 8'h05);
        u_igc_host_model.wr(`IGC_A_MODE, 8'h62);
        cyc(700);
        gains(8'h02);
        cyc(1700);
        gains(8'h05);
        u_igc_host_model.wr(`IGC_A_PWR_AUX, 8'h00);
        cyc(5);
        gains(8'h10);
        $display("test recovery done");
        u_igc_host_model.wr(`IGC_A_PWR3, 8'h19);
        u_igc_host_model.wr(`IGC_A_PWR_AUX, 8'h0a);
        cyc(3);
        gains(8'h10);
        check({1'b0, pwr}, 8'h3a);
        check({6'h00, src}, 8'h03);
        over <= 2'b01;
        cyc(1);
        over <= 2'b00;
        cyc(260);
        gains(8'h0f);
        cyc(3750);
        check({6'h00, valid, spk}, 8'h00);
        cyc(300);
        check({6'h00, valid, spk}, 8'h03);
        u_igc_host_model.rd(`IGC_A_STATUS, 8'h07);
        $display("test power done");
        give_verdict;
    end
endmodule
